// File: common/hpms_consts.vh
`ifndef HPMS_CONSTS_VH
`define HPMS_CONSTS_VH

// system clock rate, hz
`define HPMS_CLK_HZ 250000000
// reference oscillator rate, hz, and the two multipliers
`define HPMS_REF_HZ 14745600
`define HPMS_MULT_LO 4'h4
`define HPMS_MULT_HI 4'h8

// clock-mode strap codes, strap a is the msb
`define HPMS_MODE_FIXED 3'h2
`define HPMS_MODE_FAST_AUTO 3'h5
`define HPMS_MODE_SLOW_AUTO 3'h7

// serial rates in bits per second
`define HPMS_FIXED_BPS 115200
`define HPMS_MIN_BPS 300
`define HPMS_MAX_BPS 230400

// character framing: start, eight data, stop
`define HPMS_CHAR_BITS 4'hA
`define HPMS_DATA_BITS 8
`define HPMS_DIV_W 20

// host data pin roles in serial mode
`define HPMS_PIN_DTR 0
`define HPMS_PIN_RTS 1
`define HPMS_PIN_CTS 2
`define HPMS_PIN_DSR 3
`define HPMS_PIN_DCD 4
`define HPMS_PIN_RI 5
`define HPMS_PIN_MUTE 6
`define HPMS_PIN_HOOK 7
// pins the device drives in serial mode
`define HPMS_SER_OE_MASK 8'hFC

// clock output divider width, output is the msb
`define HPMS_CLKDIV_W 2

`endif

// File: core/hpms_uart.v
`timescale 1ns/1ps
`include "hpms_consts.vh"

module hpms_uart #(
  parameter DIV_W = `HPMS_DIV_W
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire [DIV_W-1:0] divisor,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output reg tx_ready,
  output reg tx_line,
  input wire rx_line,
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rx_frame_err
);

  // one-hot states, shared shape for both directions
  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  reg [1:0] tx_state_reg; // transmit state
  reg [9:0] tx_shift_reg; // stop, data, start
  reg [3:0] tx_bits_reg; // bits left in the character
  reg [DIV_W-1:0] tx_baud_reg; // cycles left in the bit

  // shift one character out lsb first
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_reg <= ST_IDLE;
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg <= 4'h0;
      tx_baud_reg <= {DIV_W{1'b0}};
      tx_ready <= 1'b1;
      tx_line <= 1'b1;
    end else if (clk_en) begin
      case (tx_state_reg)
        ST_IDLE: begin
          tx_line <= 1'b1;
          if (tx_valid && tx_ready) begin
            // 10-bit frame: stop 1, data, start 0
            tx_shift_reg <= {1'b1, tx_data, 1'b0};
            tx_bits_reg <= `HPMS_CHAR_BITS;
            tx_baud_reg <= {DIV_W{1'b0}};
            tx_ready <= 1'b0;
            tx_state_reg <= ST_SHIFT;
          end else begin
            tx_ready <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (tx_baud_reg == {DIV_W{1'b0}}) begin
            // bit boundary
            if (tx_bits_reg == 4'h0) begin
              tx_line <= 1'b1;
              tx_ready <= 1'b1;
              tx_state_reg <= ST_IDLE;
            end else begin
              tx_line <= tx_shift_reg[0];
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_bits_reg <= tx_bits_reg - 4'h1;
              tx_baud_reg <= divisor - {{(DIV_W-1){1'b0}}, 1'b1};
            end
          end else begin
            tx_baud_reg <= tx_baud_reg - {{(DIV_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          tx_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  reg [1:0] rx_state_reg; // receive state
  reg [9:0] rx_shift_reg; // collected samples
  reg [3:0] rx_bits_reg; // samples still due
  reg [DIV_W-1:0] rx_baud_reg; // cycles to next sample

  // sample at mid bit; a start glitch shows as a frame error
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state_reg <= ST_IDLE;
      rx_shift_reg <= 10'h000;
      rx_bits_reg <= 4'h0;
      rx_baud_reg <= {DIV_W{1'b0}};
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_frame_err <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      case (rx_state_reg)
        ST_IDLE: begin
          if (!rx_line) begin
            // half a bit to reach the middle of the start bit
            rx_baud_reg <= {1'b0, divisor[DIV_W-1:1]};
            rx_bits_reg <= `HPMS_CHAR_BITS;
            rx_state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rx_baud_reg == {DIV_W{1'b0}}) begin
            if (rx_bits_reg == 4'h0) begin
              // frame done: start must be 0, stop must be 1
              rx_data <= rx_shift_reg[8:1];
              rx_valid <= 1'b1;
              rx_frame_err <= rx_shift_reg[0] | ~rx_shift_reg[9];
              rx_state_reg <= ST_IDLE;
            end else begin
              rx_shift_reg <= {rx_line, rx_shift_reg[9:1]};
              rx_bits_reg <= rx_bits_reg - 4'h1;
              rx_baud_reg <= (rx_bits_reg == 4'h1) ? {DIV_W{1'b0}} :
                divisor - {{(DIV_W-1){1'b0}}, 1'b1};
            end
          end else begin
            rx_baud_reg <= rx_baud_reg - {{(DIV_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          rx_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: core/hpms_pin_mux.v
`timescale 1ns/1ps
`include "hpms_consts.vh"

module hpms_pin_mux #(
  parameter DIV_W = `HPMS_DIV_W,
  // longest bit accepted by autobaud, in clock cycles
  parameter MAX_BIT_CYCLES = `HPMS_CLK_HZ / `HPMS_MIN_BPS
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  // straps
  input wire clock_strap_a,
  input wire clock_strap_b,
  input wire clock_strap_c,
  input wire interface_type_strap,
  // strap results
  output reg [2:0] mode_code,
  output reg mode_reserved,
  output reg [3:0] pll_mult,
  output reg autobaud_en,
  output reg serial_mode,
  output reg straps_latched,
  output reg baud_locked,
  output wire divided_clock_output,
  // serial pins
  input wire serial_in_pin,
  output reg serial_out_pin,
  // shared host data pins
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output reg [7:0] host_data_oe,
  // parallel control pins
  input wire access_select_a,
  input wire access_select_b,
  input wire byte_half_flag,
  input wire host_chip_select_n,
  input wire host_strobe_a_n,
  input wire host_strobe_b_n,
  input wire host_addr_strobe_n,
  input wire host_read_write,
  output reg host_wait_ready,
  output reg host_irq_out,
  // modem core side, serial
  input wire core_tx_valid,
  input wire [7:0] core_tx_data,
  output reg core_tx_ready,
  output reg core_rx_valid,
  output reg [7:0] core_rx_data,
  output reg core_rx_frame_err,
  input wire core_cts,
  input wire core_dsr,
  input wire core_dcd,
  input wire core_ri,
  input wire core_mute,
  input wire core_off_hook,
  output reg core_dtr,
  output reg core_rts,
  // modem core side, parallel
  input wire [7:0] core_hp_data_out,
  input wire core_hp_data_oe,
  input wire core_hp_ready,
  input wire core_hp_irq,
  output reg [7:0] core_hp_data_in,
  output reg [1:0] core_hp_access_sel,
  output reg core_hp_byte_half,
  output reg core_hp_cs_n,
  output reg core_hp_strobe_a_n,
  output reg core_hp_strobe_b_n,
  output reg core_hp_addr_strobe_n,
  output reg core_hp_read_write
);

  // cycle counts derived from the clock rate, cut to the divisor width
  localparam integer FIXED_DIV_I = `HPMS_CLK_HZ / `HPMS_FIXED_BPS;
  localparam integer MIN_BIT_I = `HPMS_CLK_HZ / `HPMS_MAX_BPS;
  localparam integer MAX_BIT_I = MAX_BIT_CYCLES;
  localparam [DIV_W-1:0] FIXED_DIV = FIXED_DIV_I[DIV_W-1:0];
  localparam [DIV_W-1:0] MIN_BIT = MIN_BIT_I[DIV_W-1:0];
  localparam [DIV_W-1:0] MAX_BIT = MAX_BIT_I[DIV_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // strap capture
  wire [2:0] strap_code; // a is the msb
  assign strap_code = {clock_strap_a, clock_strap_b, clock_strap_c};

  // async reset loads constants; straps are caught by the first enabled
  // edge after release, then frozen until the next reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      straps_latched <= 1'b0;
      mode_code <= 3'h0;
      mode_reserved <= 1'b0;
      pll_mult <= `HPMS_MULT_LO;
      autobaud_en <= 1'b0;
      serial_mode <= 1'b0;
    end else if (clk_en && !straps_latched) begin
      straps_latched <= 1'b1;
      mode_code <= strap_code;
      serial_mode <= ~interface_type_strap;
      case (strap_code)
        `HPMS_MODE_FIXED: begin
          pll_mult <= `HPMS_MULT_LO;
          autobaud_en <= 1'b0;
          mode_reserved <= 1'b0;
        end
        `HPMS_MODE_FAST_AUTO: begin
          pll_mult <= `HPMS_MULT_HI;
          autobaud_en <= 1'b1;
          mode_reserved <= 1'b0;
        end
        `HPMS_MODE_SLOW_AUTO: begin
          pll_mult <= `HPMS_MULT_LO;
          autobaud_en <= 1'b1;
          mode_reserved <= 1'b0;
        end
        default: begin
          // illegal code from the system: flag it, fall back safely
          pll_mult <= `HPMS_MULT_LO;
          autobaud_en <= 1'b0;
          mode_reserved <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock output divider
  reg [`HPMS_CLKDIV_W-1:0] clkdiv_reg; // free divide-by-four counter

  // msb of a 2-bit counter is a quarter rate clock for either multiplier
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkdiv_reg <= {`HPMS_CLKDIV_W{1'b0}};
    end else if (clk_en) begin
      clkdiv_reg <= clkdiv_reg + {{(`HPMS_CLKDIV_W-1){1'b0}}, 1'b1};
    end
  end
  assign divided_clock_output = clkdiv_reg[`HPMS_CLKDIV_W-1];

  ////////////////////////////////////////////////////////////////////////
  // autobaud: time the first low pulse, the start bit of a character
  // whose first data bit is one; out of range pulses are dropped
  localparam AB_IDLE = 3'b001;
  localparam AB_LOW = 3'b010;
  localparam AB_LOCK = 3'b100;

  reg [2:0] ab_state_reg; // autobaud state
  reg [DIV_W-1:0] ab_count_reg; // width of the low pulse
  reg [DIV_W-1:0] divisor_reg; // cycles per bit for the uart
  wire serial_active; // serial mode settled after capture
  assign serial_active = straps_latched & serial_mode;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ab_state_reg <= AB_IDLE;
      ab_count_reg <= {DIV_W{1'b0}};
      divisor_reg <= FIXED_DIV;
      baud_locked <= 1'b0;
    end else if (clk_en) begin
      case (ab_state_reg)
        AB_IDLE: begin
          ab_count_reg <= {DIV_W{1'b0}};
          if (serial_active && !autobaud_en) begin
            divisor_reg <= FIXED_DIV;
            baud_locked <= 1'b1;
            ab_state_reg <= AB_LOCK;
          end else if (serial_active && !serial_in_pin) begin
            ab_state_reg <= AB_LOW;
          end
        end
        AB_LOW: begin
          if (!serial_in_pin) begin
            // saturate so a stuck line cannot wrap into range
            if (ab_count_reg != MAX_BIT) begin
              ab_count_reg <= ab_count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            end
          end else if (ab_count_reg >= MIN_BIT &&
                       ab_count_reg < MAX_BIT) begin
            divisor_reg <= ab_count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            baud_locked <= 1'b1;
            ab_state_reg <= AB_LOCK;
          end else begin
            ab_state_reg <= AB_IDLE;
          end
        end
        AB_LOCK: begin
          // rate holds until the next reset
          baud_locked <= 1'b1;
        end
        default: begin
          ab_state_reg <= AB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // uart; receive line is held idle until the rate is known, which hides
  // the timing start bit; later zeros of that character still reach the
  // receiver, so hosts should time with an all-ones character
  wire uart_rx_line; // gated receive line
  wire uart_tx_ready; // transmitter can take a byte
  wire uart_tx_line; // transmitter output
  wire uart_rx_valid; // byte received
  wire [7:0] uart_rx_data; // received byte
  wire uart_rx_err; // framing error on that byte
  assign uart_rx_line = serial_in_pin | ~baud_locked;

  hpms_uart #(
    .DIV_W(DIV_W)
  ) u_uart (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .divisor(divisor_reg),
    .tx_valid(core_tx_valid & baud_locked),
    .tx_data(core_tx_data),
    .tx_ready(uart_tx_ready),
    .tx_line(uart_tx_line),
    .rx_line(uart_rx_line),
    .rx_valid(uart_rx_valid),
    .rx_data(uart_rx_data),
    .rx_frame_err(uart_rx_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial-mode levels for the shared data pins
  wire [7:0] ser_pin_val; // driven levels, inputs read as zero
  localparam [7:0] SER_OE = `HPMS_SER_OE_MASK; // pins driven in serial
  assign ser_pin_val[`HPMS_PIN_DTR] = 1'b0;
  assign ser_pin_val[`HPMS_PIN_RTS] = 1'b0;
  assign ser_pin_val[`HPMS_PIN_CTS] = core_cts;
  assign ser_pin_val[`HPMS_PIN_DSR] = core_dsr;
  assign ser_pin_val[`HPMS_PIN_DCD] = core_dcd;
  assign ser_pin_val[`HPMS_PIN_RI] = core_ri;
  assign ser_pin_val[`HPMS_PIN_MUTE] = core_mute;
  assign ser_pin_val[`HPMS_PIN_HOOK] = core_off_hook;

  // per-pin output mux; nothing drives before the straps are caught
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          host_data_out[gi] <= 1'b0;
          host_data_oe[gi] <= 1'b0;
        end else if (clk_en) begin
          if (!straps_latched) begin
            host_data_out[gi] <= 1'b0;
            host_data_oe[gi] <= 1'b0;
          end else if (serial_mode) begin
            host_data_out[gi] <= ser_pin_val[gi];
            host_data_oe[gi] <= SER_OE[gi];
          end else begin
            host_data_out[gi] <= core_hp_data_out[gi];
            host_data_oe[gi] <= core_hp_data_oe;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // remaining pin and core-side routing, all registered
  wire par_active; // parallel mode settled after capture
  assign par_active = straps_latched & ~serial_mode;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
      core_tx_ready <= 1'b0;
      core_rx_valid <= 1'b0;
      core_rx_data <= 8'h00;
      core_rx_frame_err <= 1'b0;
      core_dtr <= 1'b0;
      core_rts <= 1'b0;
      core_hp_data_in <= 8'h00;
      core_hp_access_sel <= 2'h0;
      core_hp_byte_half <= 1'b0;
      core_hp_cs_n <= 1'b1;
      core_hp_strobe_a_n <= 1'b1;
      core_hp_strobe_b_n <= 1'b1;
      core_hp_addr_strobe_n <= 1'b1;
      core_hp_read_write <= 1'b1;
      host_wait_ready <= 1'b0;
      host_irq_out <= 1'b0;
    end else if (clk_en) begin
      // serial side: uart pins idle high in parallel mode
      serial_out_pin <= serial_active ? uart_tx_line : 1'b1;
      core_tx_ready <= serial_active & baud_locked & uart_tx_ready;
      core_rx_valid <= serial_active & uart_rx_valid;
      core_rx_data <= uart_rx_data;
      core_rx_frame_err <= serial_active & uart_rx_err;
      core_dtr <= serial_active & host_data_in[`HPMS_PIN_DTR];
      core_rts <= serial_active & host_data_in[`HPMS_PIN_RTS];
      // parallel side: controls pass only in parallel mode, else idle
      if (par_active) begin
        core_hp_data_in <= host_data_in;
        core_hp_access_sel <= {access_select_b, access_select_a};
        core_hp_byte_half <= byte_half_flag;
        core_hp_cs_n <= host_chip_select_n;
        core_hp_strobe_a_n <= host_strobe_a_n;
        core_hp_strobe_b_n <= host_strobe_b_n;
        core_hp_addr_strobe_n <= host_addr_strobe_n;
        core_hp_read_write <= host_read_write;
        host_wait_ready <= core_hp_ready;
        host_irq_out <= core_hp_irq;
      end else begin
        core_hp_data_in <= 8'h00;
        core_hp_access_sel <= 2'h0;
        core_hp_byte_half <= 1'b0;
        core_hp_cs_n <= 1'b1;
        core_hp_strobe_a_n <= 1'b1;
        core_hp_strobe_b_n <= 1'b1;
        core_hp_addr_strobe_n <= 1'b1;
        core_hp_read_write <= 1'b1;
        host_wait_ready <= 1'b0;
        host_irq_out <= 1'b0;
      end
    end
  end

endmodule

// File: testbench/hpms_pin_mux_checker.sv
`timescale 1ns/1ps
`include "hpms_consts.vh"

// strap capture, clock divider and pin routing watcher
module hpms_pin_mux_checker (
  input wire clk_sys,
  input wire rst,
  input wire clock_strap_a,
  input wire clock_strap_b,
  input wire clock_strap_c,
  input wire interface_type_strap,
  input wire [2:0] mode_code,
  input wire mode_reserved,
  input wire [3:0] pll_mult,
  input wire autobaud_en,
  input wire serial_mode,
  input wire straps_latched,
  input wire baud_locked,
  input wire divided_clock_output,
  input wire [7:0] host_data_oe,
  input wire [7:0] host_data_out,
  input wire core_cts,
  input wire core_dsr,
  input wire core_dcd,
  input wire core_ri,
  input wire core_mute,
  input wire core_off_hook,
  input wire [7:0] core_hp_data_out,
  input wire core_hp_data_oe,
  input wire host_wait_ready,
  input wire host_irq_out
);
  // single domain, so one clocking and one disable
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // capture and decode; routing checks wait one edge past capture
  a_strap_capture: assert property (
    $rose(straps_latched) |-> serial_mode == !$past(interface_type_strap)
    && mode_code == {$past(clock_strap_a), $past(clock_strap_b),
    $past(clock_strap_c)}) else $error("strap capture wrong");
  a_mult_select: assert property (
    straps_latched |-> pll_mult == ((mode_code == `HPMS_MODE_FAST_AUTO) ?
    `HPMS_MULT_HI : `HPMS_MULT_LO)) else $error("multiplier wrong");
  a_mode_decode: assert property (
    straps_latched |-> autobaud_en == (mode_code == 3'h5 || mode_code == 3'h7)
    && mode_reserved == !(autobaud_en || mode_code == 3'h2))
    else $error("mode decode wrong");
  a_fixed_lock: assert property (
    $rose(straps_latched) && mode_code == 3'h2 && serial_mode |=> baud_locked)
    else $error("fixed rate not locked");
  a_straps_hold: assert property (
    straps_latched && $past(straps_latched) |-> $stable(mode_code)
    && $stable(serial_mode)) else $error("straps changed");
  a_clock_quarter: assert property (
    $rose(divided_clock_output) |=> divided_clock_output
    ##1 !divided_clock_output [*2] ##1 divided_clock_output)
    else $error("clock out not quarter rate");
  a_serial_pins: assert property (
    straps_latched && $past(straps_latched) && serial_mode |->
    host_data_oe == `HPMS_SER_OE_MASK && host_data_out == {$past(core_off_hook),
    $past(core_mute), $past(core_ri), $past(core_dcd), $past(core_dsr),
    $past(core_cts), 2'h0}) else $error("serial pin roles wrong");
  a_parallel_pins: assert property (
    straps_latched && $past(straps_latched) && !serial_mode |->
    host_data_oe == {8{$past(core_hp_data_oe)}}
    && host_data_out == $past(core_hp_data_out)) else $error("bus wrong");
  a_serial_quiet: assert property (
    straps_latched && $past(straps_latched) && serial_mode |->
    !host_wait_ready && !host_irq_out) else $error("port pins active");
endmodule

bind hpms_pin_mux hpms_pin_mux_checker hpms_pin_mux_checker_i (.*);

// File: testbench/hpms_host_model.sv
`timescale 1ns/1ps

// host terminal sending one character on its transmit line
module hpms_host_model (
  input wire clk_sys,
  input wire send,
  input wire [19:0] bit_cycles,
  input wire [7:0] byte_in,
  output reg serial_in_pin,
  output reg busy
);
  reg [9:0] frame; // stop, data, start
  integer i;
  ////////////////////////////////////////
  // line rests at mark; requests while busy are not seen
  initial begin
    serial_in_pin = 1'h1;
    busy = 1'h0;
    forever begin
      @(posedge clk_sys);
      if (send === 1'h1) begin
        busy <= 1'h1;
        frame = {1'h1, byte_in, 1'h0};
        for (i = 0; i < 10; i = i + 1) begin
          serial_in_pin <= frame[i];
          repeat (bit_cycles) @(posedge clk_sys);
        end
        busy <= 1'h0;
      end
    end
  end
endmodule

// File: testbench/hpms_pin_mux_bench.sv
`timescale 1ns/1ps
`include "hpms_consts.vh"

module hpms_pin_mux_bench;
  localparam integer BIT_FIX = `HPMS_CLK_HZ / `HPMS_FIXED_BPS; // fixed bit
  localparam integer BIT_AUTO = 1300; // host bit time for autobaud
  // rows: code, parallel strap, multiplier, autobaud
  localparam logic [8:0] ROWS [0:5] = '{
    {3'h2, 1'h1, 4'h4, 1'h0}, {3'h2, 1'h0, 4'h4, 1'h0},
    {3'h5, 1'h1, 4'h8, 1'h1}, {3'h5, 1'h0, 4'h8, 1'h1},
    {3'h7, 1'h1, 4'h4, 1'h1}, {3'h7, 1'h0, 4'h4, 1'h1}};
  reg clk_sys = 1'h0, rst = 1'h1, clk_en = 1'h1, clock_strap_a = 1'h0;
  reg clock_strap_b = 1'h1, clock_strap_c = 1'h0, interface_type_strap = 1'h1;
  reg access_select_a = 1'h0, access_select_b = 1'h0, byte_half_flag = 1'h0;
  reg host_chip_select_n = 1'h1, host_strobe_a_n = 1'h1, h_send = 1'h0;
  reg host_strobe_b_n = 1'h1, host_addr_strobe_n = 1'h1, core_ri = 1'h0;
  reg host_read_write = 1'h1, core_tx_valid = 1'h0, core_cts = 1'h0;
  reg core_dsr = 1'h0, core_dcd = 1'h0, core_mute = 1'h0, core_hp_irq = 1'h0;
  reg core_off_hook = 1'h0, core_hp_data_oe = 1'h0, core_hp_ready = 1'h0;
  reg [7:0] host_drv = 8'h00, core_tx_data = 8'h00, core_hp_data_out = 8'h00;
  reg [7:0] h_byte = 8'h00;
  reg [19:0] h_bits = 20'h00001;
  reg [9:0] frame; // expected transmit frame
  wire [2:0] mode_code;
  wire [3:0] pll_mult;
  wire [1:0] core_hp_access_sel;
  wire [7:0] host_data_out, host_data_oe, core_rx_data, core_hp_data_in;
  wire mode_reserved, autobaud_en, serial_mode, straps_latched, baud_locked;
  wire divided_clock_output, serial_in_pin, serial_out_pin, h_busy;
  wire host_wait_ready, host_irq_out, core_tx_ready, core_rx_valid;
  wire core_rx_frame_err, core_dtr, core_rts, core_hp_byte_half;
  wire core_hp_cs_n, core_hp_strobe_a_n, core_hp_strobe_b_n;
  wire core_hp_addr_strobe_n, core_hp_read_write;
  // shared data wire: device bits where enabled, host elsewhere
  wire [7:0] host_data_in = (host_data_oe & host_data_out)
    | (~host_data_oe & host_drv);
  integer failures = 0, checks = 0, n, i;

  always #2 clk_sys = ~clk_sys;
  // short autobaud ceiling keeps the run brief
  hpms_pin_mux #(.MAX_BIT_CYCLES(5000)) hpms_pin_mux_i (.*);
  hpms_host_model hpms_host_model_i (.clk_sys(clk_sys), .send(h_send),
    .bit_cycles(h_bits), .byte_in(h_byte), .serial_in_pin(serial_in_pin),
    .busy(h_busy));
  ////////////////////////////////////////
  task report_and_stop;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp, input string what);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  // a used-up bound ends the run as a failure
  task limit(input integer cnt, input integer lim);
    begin
      if (cnt >= lim) begin
        failures = failures + 1;
        $display("BAD %0t wait ran out", $time);
        report_and_stop;
      end
    end
  endtask
  // straps set under reset, then capture and routing settle
  task do_reset(input [2:0] code, input par);
    begin
      @(posedge clk_sys);
      rst <= 1'h1;
      {clock_strap_a, clock_strap_b, clock_strap_c} <= code;
      interface_type_strap <= par;
      repeat (12) @(posedge clk_sys);
      check(host_data_oe, 8'h00, "reset oe");
      check({7'h0, serial_out_pin}, 8'h01, "reset tx");
      rst <= 1'h0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  // host sends a char once its previous one is done
  task host_char(input [7:0] b, input [19:0] bits);
    begin
      @(posedge clk_sys);
      n = 0;
      while (h_busy !== 1'h0 && n < 30000) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      limit(n, 30000);
      h_byte <= b;
      h_bits <= bits;
      h_send <= 1'h1;
      @(posedge clk_sys);
      h_send <= 1'h0;
    end
  endtask
  task wait_rx;
    begin
      n = 0;
      while (core_rx_valid !== 1'h1 && n < 40000) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      limit(n, 40000);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    for (i = 0; i < 6; i = i + 1) begin
      do_reset(ROWS[i][8:6], ROWS[i][5]);
      check({5'h0, mode_code}, {5'h0, ROWS[i][8:6]}, "code");
      check({4'h0, pll_mult}, {4'h0, ROWS[i][4:1]}, "mult");
      check({autobaud_en, baud_locked, mode_reserved, serial_mode},
        {ROWS[i][0], !ROWS[i][0] && !ROWS[i][5], 1'h0, !ROWS[i][5]},
        "mode");
      check(host_data_oe, ROWS[i][5] ? 8'h00 : 8'hFC, "oe");
    end
    // reserved code: flagged, slow multiplier, no autobaud, no lock
    do_reset(3'h3, 1'h1);
    check({pll_mult, autobaud_en, baud_locked, mode_reserved, serial_mode},
      8'h42, "reserved");
    // parallel: host write, then device drives the bus
    do_reset(3'h5, 1'h1);
    @(posedge clk_sys);
    {access_select_b, access_select_a, byte_half_flag} <= 3'h3;
    {host_chip_select_n, host_strobe_a_n, host_strobe_b_n} <= 3'h1;
    {host_addr_strobe_n, host_read_write} <= 2'h0;
    {core_hp_ready, core_hp_irq, host_drv} <= 10'h3C3;
    core_hp_data_out <= 8'h3C;
    repeat (3) @(negedge clk_sys);
    check({core_hp_access_sel, core_hp_byte_half, core_hp_cs_n,
      core_hp_strobe_a_n, core_hp_strobe_b_n, core_hp_addr_strobe_n,
      core_hp_read_write}, 8'h64, "controls");
    check(core_hp_data_in, 8'hC3, "bus in");
    check({6'h0, host_wait_ready, host_irq_out}, 8'h03, "rdy irq");
    @(posedge clk_sys);
    core_hp_data_oe <= 1'h1;
    repeat (3) @(negedge clk_sys);
    check(host_data_oe, 8'hFF, "bus oe");
    check(host_data_out, 8'h3C, "bus out");
    // serial fixed rate; port controls stay asserted, straps move late
    do_reset(3'h2, 1'h0);
    @(posedge clk_sys);
    {core_off_hook, core_mute, core_ri, core_dcd, core_dsr, core_cts} <= 6'h2D;
    host_drv <= 8'h02;
    {clock_strap_a, clock_strap_b, clock_strap_c, interface_type_strap} <= 4'hF;
    repeat (4) @(negedge clk_sys);
    check(host_data_out, 8'hB4, "lines out");
    check({6'h0, core_rts, core_dtr}, 8'h02, "lines in");
    check({core_hp_access_sel, core_hp_byte_half, core_hp_cs_n,
      core_hp_strobe_a_n, core_hp_strobe_b_n, core_hp_addr_strobe_n,
      core_hp_read_write}, 8'h1F, "idle ctl");
    check({6'h0, host_wait_ready, host_irq_out}, 8'h00, "quiet");
    check({4'h0, mode_code, serial_mode}, 8'h05, "held");
    check({7'h0, core_tx_ready}, 8'h01, "tx ready");
    @(posedge clk_sys);
    core_tx_data <= 8'hA5;
    core_tx_valid <= 1'h1;
    n = 0;
    while (serial_out_pin !== 1'h0 && n < 100) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    limit(n, 100);
    @(posedge clk_sys);
    core_tx_valid <= 1'h0;
    frame = {1'h1, 8'hA5, 1'h0};
    repeat (BIT_FIX / 2) @(negedge clk_sys);
    for (i = 0; i < 10; i = i + 1) begin
      check({7'h0, serial_out_pin}, {7'h0, frame[i]}, "tx bit");
      repeat (BIT_FIX) @(negedge clk_sys);
    end
    host_char(8'h96, BIT_FIX);
    wait_rx;
    check(core_rx_data, 8'h96, "rx");
    check({7'h0, core_rx_frame_err}, 8'h00, "rx frame");
    // autobaud: all-ones timing char, then real data; zeros after
    // its start bit would open a false frame once the rate is locked
    do_reset(3'h7, 1'h0);
    check({7'h0, baud_locked}, 8'h00, "early lock");
    host_char(8'hFF, BIT_AUTO);
    host_char(8'h5A, BIT_AUTO);
    check({7'h0, baud_locked}, 8'h01, "lock");
    wait_rx;
    check(core_rx_data, 8'h5A, "auto rx");
    report_and_stop;
  end
endmodule
